// ---- sec_flash_pkg.sv ----
// Constants and types shared by the security page command block
package sec_flash_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int ERASE_TIME_US = 1000;
    localparam int PROG_TIME_US  = 500;
    localparam int ERASE_CYCLES  = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES   = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_SEC_ERASE  = 8'h44;
    localparam logic [7:0] OP_SEC_PROG   = 8'h42;
    localparam logic [7:0] OP_SEC_READ   = 8'h48;
    localparam logic [7:0] OP_STAT_ONE   = 8'h05;
    localparam logic [7:0] OP_STAT_TWO   = 8'h35;

    // ------------------------------------------------------------------
    // Frame layout and page addressing
    // ------------------------------------------------------------------
    localparam logic [2:0] BYTE_OPCODE   = 3'h0;
    localparam logic [2:0] BYTE_ADDR_LO  = 3'h3;
    localparam logic [2:0] BYTE_FIRST_WR = 3'h4;
    localparam logic [2:0] BYTE_FIRST_RD = 3'h5;
    localparam logic [2:0] BYTE_SAT      = 3'h7;
    localparam logic [7:0] PAGE_HI_ADDR  = 8'h00;
    localparam logic [7:0] PAGE_FIRST    = 8'h01;
    localparam logic [7:0] PAGE_LAST     = 8'h03;
    localparam int         SEC_PAGES     = 3;
    localparam int         PAGE_BYTES    = 256;

    // ------------------------------------------------------------------
    // Status fields and reset values
    // ------------------------------------------------------------------
    localparam int         LOCK_LSB_TWO  = 3;
    localparam logic       WEL_RESET     = 1'b0;
    localparam logic [7:0] ERASED_BYTE   = 8'hFF;

    typedef struct packed {
        logic       status_protect_bit0;
        logic       sector_granularity_select;
        logic       top_bottom_select;
        logic [2:0] block_protect;
        logic       write_enable_latch;
        logic       ready_busy_flag;
    } status_one_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASING,
        ST_PROGRAMMING
    } busy_state_e;

endpackage

// ---- security_page_flash.sv ----
// Security page erase, program, read and status read command logic
//
// Contract
// - Erase is opcode 44h plus three address bytes; starts at select release.
// - Erase ignores the low address byte; upper two bytes pick the page.
// - Erase aborts unless select rises right after the last address bit.
// - Status reports busy while an accepted erase runs.
// - Aborted erase for bad address, boundary or protection clears the latch.
// - A page whose lock bit is one ignores erase commands.
// - Pages are upper byte 00h and middle byte 01h to 03h.
// - Page program overwrites the shared page buffer when issued.
// - Program needs the latch; opcode 42h, three address bytes, low byte is start.
// - Read is 48h, three address bytes, one dummy byte, then data out.
// - Read wraps from the last address to zero with no delay.
// - Select release ends a read at once and floats the output.
// - Status reads are accepted at all times, even while busy.
// - After 05h status byte one streams MSB first, repeating from bit 7.
// - After 35h status byte two streams the same repeating way.
// - Every repetition of the status byte carries fresh status.
// - Status byte one bits 7 to 2 hold the protection fields.
// - Bit 1 is the read-only write enable latch, reset to 0.
// - Bit 0 is the read-only busy flag.
// - Only bits 7 to 2 come from the protection fields.
// - Opcode 06h on a byte boundary sets the latch; otherwise unchanged.
// - Program or erase with a full opcode clears the latch.
`timescale 1ns/1ps

module security_page_flash #(
    parameter int ERASE_CYCLES = sec_flash_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES  = sec_flash_pkg::PROG_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       spi_clk,
    input  wire logic       cs_n,
    input  wire logic       si,
    output logic            so,
    output logic            so_oe,
    input  wire logic [5:0] protect_bits,
    input  wire logic [2:0] page_lock_bits
);

    localparam int TW = $clog2(((ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES) + 1);
    localparam int PB = sec_flash_pkg::PAGE_BYTES;

    if (ERASE_CYCLES < 1 || PROG_CYCLES < 1)
    begin : g_bad_timing
        $error("Operation times must be at least one cycle");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic page_ok(input logic [23:0] a);
        page_ok = (a[23:16] == sec_flash_pkg::PAGE_HI_ADDR)
               && (a[15:8] >= sec_flash_pkg::PAGE_FIRST)
               && (a[15:8] <= sec_flash_pkg::PAGE_LAST);
    endfunction

    // Storage array shared by both domains
    logic [7:0] mem_q [sec_flash_pkg::SEC_PAGES][PB];

    // Read side holds page 0 as erased, since only pages 1 to 3 exist
    function automatic logic [7:0] mem_read(input logic [9:0] p);
        if (p[9:8] == 2'h0)
        begin
            mem_read = sec_flash_pkg::ERASED_BYTE;
        end
        else
        begin
            mem_read = mem_q[p[9:8] - 2'h1][p[7:0]];
        end
    endfunction

    // ------------------------------------------------------------------
    // Link domain: frame decode
    // ------------------------------------------------------------------
    logic                      in_frame_q;
    logic [2:0]                bit_cnt_q;
    logic [2:0]                byte_cnt_q;
    logic [6:0]                sh_q;
    logic [7:0]                opcode_q;
    logic [23:0]               addr_q;
    logic                      frame_tgl_q;
    logic [9:0]                rd_ptr_q;
    logic [7:0]                rd_byte_q;
    logic [7:0]                wr_idx_q;
    logic [7:0]                buf_q [PB];
    logic [PB-1:0]             buf_mask_q;
    logic [10:0]               stat_meta_q;
    logic [10:0]               stat_sync_q;
    sec_flash_pkg::status_one_s stat_one_q;
    logic [7:0]                stat_two_q;
    logic                      wel_q;
    logic                      busy_q;

    logic [2:0] cur_bit;
    logic [2:0] cur_byte;
    logic       byte_done;
    logic [7:0] byte_in;

    assign cur_bit   = in_frame_q ? bit_cnt_q : 3'h0;
    assign cur_byte  = in_frame_q ? byte_cnt_q : 3'h0;
    assign byte_done = (cur_bit == 3'h7);
    assign byte_in   = {sh_q, si};

    // Frame flag clears on select release; counters stay for the other domain
    always_ff @(posedge spi_clk or posedge cs_n or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_frame_q <= 1'b0;
        end
        else if (cs_n)
        begin
            in_frame_q <= 1'b0;
        end
        else
        begin
            in_frame_q <= 1'b1;
        end
    end

    always_ff @(posedge spi_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt_q   <= 3'h0;
            byte_cnt_q  <= 3'h0;
            sh_q        <= 7'h00;
            frame_tgl_q <= 1'b0;
        end
        else
        begin
            bit_cnt_q <= cur_bit + 3'h1;
            sh_q      <= byte_in[6:0];
            if (byte_done && cur_byte != sec_flash_pkg::BYTE_SAT)
            begin
                byte_cnt_q <= cur_byte + 3'h1;
            end
            else
            begin
                byte_cnt_q <= cur_byte;
            end
            if (!in_frame_q)
            begin
                frame_tgl_q <= ~frame_tgl_q;
            end
        end
    end

    always_ff @(posedge spi_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opcode_q <= 8'h00;
            addr_q   <= 24'h000000;
        end
        else if (byte_done && cur_byte == sec_flash_pkg::BYTE_OPCODE)
        begin
            opcode_q <= byte_in;
        end
        else if (byte_done && cur_byte <= sec_flash_pkg::BYTE_ADDR_LO)
        begin
            addr_q <= {addr_q[15:0], byte_in};
        end
    end

    // Status sampled on every byte boundary so each repeat is fresh
    always_ff @(posedge spi_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_meta_q <= 11'h000;
            stat_sync_q <= 11'h000;
            stat_one_q  <= '0;
            stat_two_q  <= 8'h00;
        end
        else
        begin
            stat_meta_q <= {protect_bits, wel_q, busy_q, page_lock_bits};
            stat_sync_q <= stat_meta_q;
            if (byte_done)
            begin
                stat_one_q <= stat_sync_q[10:3];
                stat_two_q <= {2'h0, stat_sync_q[2:0], 3'h0};
            end
        end
    end

    // Read pointer covers 10 address bits, so the top address wraps to 0
    always_ff @(posedge spi_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_ptr_q  <= 10'h000;
            rd_byte_q <= 8'h00;
        end
        else if (byte_done && cur_byte == sec_flash_pkg::BYTE_ADDR_LO)
        begin
            rd_ptr_q <= {addr_q[1:0], byte_in};
        end
        else if (byte_done && cur_byte >= sec_flash_pkg::BYTE_FIRST_WR
                 && opcode_q == sec_flash_pkg::OP_SEC_READ)
        begin
            rd_byte_q <= mem_read(rd_ptr_q);
            rd_ptr_q  <= rd_ptr_q + 10'h001;
        end
    end

    // Page buffer: issuing the program opcode discards old contents
    always_ff @(posedge spi_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_mask_q <= '0;
            wr_idx_q   <= 8'h00;
        end
        else if (byte_done && cur_byte == sec_flash_pkg::BYTE_OPCODE
                 && byte_in == sec_flash_pkg::OP_SEC_PROG)
        begin
            buf_mask_q <= '0;
        end
        else if (byte_done && cur_byte == sec_flash_pkg::BYTE_ADDR_LO)
        begin
            wr_idx_q <= byte_in;
        end
        else if (byte_done && cur_byte >= sec_flash_pkg::BYTE_FIRST_WR
                 && opcode_q == sec_flash_pkg::OP_SEC_PROG)
        begin
            buf_mask_q[wr_idx_q] <= 1'b1;
            wr_idx_q             <= wr_idx_q + 8'h01;
        end
    end

    always_ff @(posedge spi_clk)
    begin
        if (byte_done && cur_byte >= sec_flash_pkg::BYTE_FIRST_WR
            && opcode_q == sec_flash_pkg::OP_SEC_PROG)
        begin
            buf_q[wr_idx_q] <= byte_in;
        end
    end

    // ------------------------------------------------------------------
    // Link domain: serial output on the falling edge
    // ------------------------------------------------------------------
    always_ff @(negedge spi_clk or posedge cs_n or negedge rst_n)
    begin
        if (!rst_n)
        begin
            so    <= 1'b0;
            so_oe <= 1'b0;
        end
        else if (cs_n)
        begin
            so_oe <= 1'b0;
        end
        else if (byte_cnt_q != 3'h0 && opcode_q == sec_flash_pkg::OP_STAT_ONE)
        begin
            so_oe <= 1'b1;
            so    <= stat_one_q[~bit_cnt_q];
        end
        else if (byte_cnt_q != 3'h0 && opcode_q == sec_flash_pkg::OP_STAT_TWO)
        begin
            so_oe <= 1'b1;
            so    <= stat_two_q[~bit_cnt_q];
        end
        else if (byte_cnt_q >= sec_flash_pkg::BYTE_FIRST_RD
                 && opcode_q == sec_flash_pkg::OP_SEC_READ)
        begin
            so_oe <= 1'b1;
            so    <= rd_byte_q[~bit_cnt_q];
        end
        else
        begin
            so_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // System domain: frame end detection
    // ------------------------------------------------------------------
    // Frame fields are frozen once select is high, so they are read after the
    // synchronised release; the toggle rejects releases with no clocks.
    logic        cs_meta_q;
    logic        cs_sync_q;
    logic        cs_prev_q;
    logic        tgl_meta_q;
    logic        tgl_sync_q;
    logic        tgl_seen_q;
    logic [2:0]  lock_meta_q;
    logic [2:0]  lock_sync_q;
    logic        frame_end;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_meta_q   <= 1'b1;
            cs_sync_q   <= 1'b1;
            cs_prev_q   <= 1'b1;
            tgl_meta_q  <= 1'b0;
            tgl_sync_q  <= 1'b0;
            tgl_seen_q  <= 1'b0;
            lock_meta_q <= 3'h0;
            lock_sync_q <= 3'h0;
        end
        else
        begin
            cs_meta_q   <= cs_n;
            cs_sync_q   <= cs_meta_q;
            cs_prev_q   <= cs_sync_q;
            tgl_meta_q  <= frame_tgl_q;
            tgl_sync_q  <= tgl_meta_q;
            lock_meta_q <= page_lock_bits;
            lock_sync_q <= lock_meta_q;
            if (frame_end)
            begin
                tgl_seen_q <= tgl_sync_q;
            end
        end
    end

    assign frame_end = cs_sync_q && !cs_prev_q && (tgl_sync_q != tgl_seen_q);

    logic full_op;
    logic on_boundary;
    logic target_ok;
    logic erase_go;
    logic prog_go;

    assign full_op     = (byte_cnt_q != 3'h0);
    assign on_boundary = (bit_cnt_q == 3'h0);
    assign target_ok   = page_ok(addr_q) && !lock_sync_q[addr_q[9:8] - 2'h1];
    assign erase_go    = frame_end && !busy_q && wel_q && on_boundary && target_ok
                      && opcode_q == sec_flash_pkg::OP_SEC_ERASE
                      && byte_cnt_q == sec_flash_pkg::BYTE_FIRST_WR;
    assign prog_go     = frame_end && !busy_q && wel_q && on_boundary && target_ok
                      && opcode_q == sec_flash_pkg::OP_SEC_PROG
                      && byte_cnt_q > sec_flash_pkg::BYTE_ADDR_LO
                      && (|buf_mask_q);

    // ------------------------------------------------------------------
    // System domain: write enable latch
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wel_q <= sec_flash_pkg::WEL_RESET;
        end
        else if (frame_end && !busy_q && full_op)
        begin
            if (opcode_q == sec_flash_pkg::OP_WR_ENABLE && on_boundary)
            begin
                wel_q <= 1'b1;
            end
            else if (opcode_q == sec_flash_pkg::OP_WR_DISABLE && on_boundary)
            begin
                wel_q <= 1'b0;
            end
            else if (opcode_q == sec_flash_pkg::OP_SEC_ERASE
                     || opcode_q == sec_flash_pkg::OP_SEC_PROG)
            begin
                wel_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // System domain: self-timed operations
    // ------------------------------------------------------------------
    sec_flash_pkg::busy_state_e state_q;
    logic [TW-1:0]             timer_q;
    logic [1:0]                tgt_q;
    logic                      apply_erase;
    logic                      apply_prog;

    assign apply_erase = (state_q == sec_flash_pkg::ST_ERASING) && (timer_q == '0);
    assign apply_prog  = (state_q == sec_flash_pkg::ST_PROGRAMMING) && (timer_q == '0);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= sec_flash_pkg::ST_IDLE;
            timer_q <= '0;
            tgt_q   <= 2'h0;
            busy_q  <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                sec_flash_pkg::ST_IDLE:
                begin
                    tgt_q <= addr_q[9:8] - 2'h1;
                    if (erase_go)
                    begin
                        state_q <= sec_flash_pkg::ST_ERASING;
                        timer_q <= TW'(ERASE_CYCLES - 1);
                        busy_q  <= 1'b1;
                    end
                    else if (prog_go)
                    begin
                        state_q <= sec_flash_pkg::ST_PROGRAMMING;
                        timer_q <= TW'(PROG_CYCLES - 1);
                        busy_q  <= 1'b1;
                    end
                end
                sec_flash_pkg::ST_ERASING,
                sec_flash_pkg::ST_PROGRAMMING:
                begin
                    if (timer_q == '0)
                    begin
                        state_q <= sec_flash_pkg::ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                    else
                    begin
                        timer_q <= timer_q - TW'(1);
                    end
                end
            endcase
        end
    end

    // Programming can only clear bits, as in the cells themselves
    for (genvar p = 0; p < sec_flash_pkg::SEC_PAGES; p++)
    begin : g_page
        for (genvar b = 0; b < PB; b++)
        begin : g_byte
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    mem_q[p][b] <= sec_flash_pkg::ERASED_BYTE;
                end
                else if (apply_erase && tgt_q == 2'(p))
                begin
                    mem_q[p][b] <= sec_flash_pkg::ERASED_BYTE;
                end
                else if (apply_prog && tgt_q == 2'(p) && buf_mask_q[b])
                begin
                    mem_q[p][b] <= mem_q[p][b] & buf_q[b];
                end
            end
        end
    end

endmodule // security_page_flash

// ---- security_page_flash_checker.sv ----
// Port assertions for the security page command block
`timescale 1ns/1ps
module security_page_flash_checker (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       spi_clk,
    input wire logic       cs_n,
    input wire logic       si,
    input wire logic       so,
    input wire logic       so_oe,
    input wire logic [5:0] protect_bits,
    input wire logic [2:0] page_lock_bits
);
    logic [15:0] bit_cnt_q;
    logic [7:0]  op_q;
    logic [7:0]  byte_two;
    assign byte_two = {2'h0, page_lock_bits, 3'h0};
    // Count restarts per frame; select release clears it at once
    always_ff @(posedge spi_clk or posedge cs_n or negedge rst_n)
    begin
        if (!rst_n || cs_n)
        begin
            bit_cnt_q <= 16'h0000;
            op_q      <= 8'h00;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_q + 16'h0001;
            if (bit_cnt_q < 16'h0008)
                op_q <= {op_q[6:0], si};
        end
    end
    AST_OE_IDLE:
        assert property (@(posedge sys_clk) disable iff (!rst_n) cs_n |-> !so_oe)
        else $error("output driven outside a frame");
    AST_OE_RISE:
        assert property (@(posedge sys_clk) disable iff (!rst_n) $rose(so_oe) |-> !cs_n)
        else $error("output enabled without select");
    AST_EARLY_QUIET:
        assert property (@(posedge spi_clk) disable iff (!rst_n || cs_n)
            (bit_cnt_q < 16'h0008 || (op_q == 8'h48 && bit_cnt_q < 16'h0028)) |-> !so_oe)
        else $error("output enabled too early");
    AST_STAT_ON:
        assert property (@(posedge spi_clk) disable iff (!rst_n || cs_n)
            (bit_cnt_q == 16'h0008 && (op_q == 8'h05 || op_q == 8'h35)) |-> so_oe)
        else $error("status not driven after opcode");
    AST_READ_ON:
        assert property (@(posedge spi_clk) disable iff (!rst_n || cs_n)
            (bit_cnt_q == 16'h0028 && op_q == 8'h48) |-> so_oe)
        else $error("read data not driven after dummy byte");
    AST_STAT_ONE:
        assert property (@(posedge spi_clk) disable iff (!rst_n || cs_n)
            (op_q == 8'h05 && bit_cnt_q >= 16'h0008 && bit_cnt_q[2:0] < 3'h6)
            |-> so == protect_bits[3'h5 - bit_cnt_q[2:0]])
        else $error("status one field bit wrong");
    AST_STAT_TWO:
        assert property (@(posedge spi_clk) disable iff (!rst_n || cs_n)
            (op_q == 8'h35 && bit_cnt_q >= 16'h0010) |-> so == byte_two[3'h7 - bit_cnt_q[2:0]])
        else $error("status two bit wrong");
    AST_OE_HOLD:
        assert property (@(posedge spi_clk) disable iff (!rst_n || cs_n)
            so_oe ##1 (!cs_n && bit_cnt_q != 16'h0000) |-> so_oe)
        else $error("output stream broke inside a frame");
endmodule // security_page_flash_checker

bind security_page_flash security_page_flash_checker chk_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .protect_bits(protect_bits), .page_lock_bits(page_lock_bits));

// ---- spi_host_model.sv ----
// Mode 0 serial host that frames commands for the block
`timescale 1ns/1ps
module spi_host_model (
    output logic      spi_clk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial
    begin
        spi_clk = 1'b0;
        cs_n    = 1'b1;
        si      = 1'b0;
    end
    // Clock stands still outside frames; odd offset keeps phase unrelated
    task automatic open_frame();
        #7 cs_n = 1'b0;
        #6;
    endtask
    // A floating output reads as unknown so it can never match
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            #6 spi_clk = 1'b1;
            rx[i] = so_oe ? so : 1'bx;
            #6 spi_clk = 1'b0;
        end
    endtask
    // Gap covers the frame end sync in the system domain
    task automatic close_frame();
        #6 cs_n = 1'b1;
        si = ~si;
        #200;
    endtask
endmodule // spi_host_model

// ---- test_security_page_flash.sv ----
// Self-checking bench for the security page command block
`timescale 1ns/1ps
module test_security_page_flash;
    logic       sys_clk        = 1'b0;
    logic       rst_n          = 1'b0;
    logic [5:0] protect_bits   = 6'h2D;
    logic [2:0] page_lock_bits = 3'h0;
    logic       spi_clk;
    logic       cs_n;
    logic       si;
    logic       so;
    logic       so_oe;
    logic [7:0] rx;
    logic [7:0] st;
    logic       busy_seen;
    int         error_cnt = 0;
    int         checked   = 0;
    int         cycles    = 0;

    always #20 sys_clk = ~sys_clk;

    security_page_flash #(.ERASE_CYCLES(20), .PROG_CYCLES(10)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n), .si(si),
        .so(so), .so_oe(so_oe), .protect_bits(protect_bits), .page_lock_bits(page_lock_bits));
    spi_host_model host_u (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [47:0] b, input int nbits);
        for (int i = 0; i < nbits; i += 8)
            host_u.shift(b[47 - i -: 8], (nbits - i > 8) ? 8 : nbits - i, rx);
    endtask
    task automatic cmd(input logic [47:0] b, input int nbits);
        host_u.open_frame();
        send(b, nbits);
        host_u.close_frame();
    endtask
    task automatic wen();
        cmd(48'h0600_0000_0000, 8);
    endtask
    // Second byte is used: latch and busy need two clocks to resync
    task automatic stat(input logic [7:0] op, output logic [7:0] v);
        host_u.open_frame();
        send({op, 40'h0}, 24);
        v = rx;
        host_u.close_frame();
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e0, input logic [7:0] e1);
        host_u.open_frame();
        send({8'h48, 14'h0, a, 16'h0}, 40);
        host_u.shift(8'h00, 8, rx);
        check("read byte", rx, e0);
        host_u.shift(8'h00, 8, rx);
        check("next byte", rx, e1);
        host_u.close_frame();
    endtask
    // One streamed status frame until ready, bounded
    task automatic poll();
        busy_seen = 1'b0;
        host_u.open_frame();
        host_u.shift(8'h05, 8, rx);
        for (int i = 0; i < 60; i++)
        begin
            host_u.shift(8'hFF, 8, rx);
            busy_seen = busy_seen | (rx[0] === 1'b1);
            if (i > 1 && rx[0] === 1'b0)
                break;
        end
        host_u.close_frame();
        check("ready", {7'h00, rx[0]}, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        stat(8'h05, st);
        check("status reset", st, {protect_bits, 2'h0});
        cmd(48'h0600_0000_0000, 7);
        stat(8'h05, st);
        check("latch short", st, {protect_bits, 2'h0});
        wen();
        stat(8'h05, st);
        check("latch set", st, {protect_bits, 2'h2});
        cmd(48'h0400_0000_0000, 8);
        stat(8'h05, st);
        check("latch disabled", st, {protect_bits, 2'h0});
        wen();
        cmd(48'h4200_01FE_A53C, 48);
        poll();
        stat(8'h05, st);
        check("latch after program", st, {protect_bits, 2'h0});
        wen();
        cmd(48'h4200_03FF_5A77, 48);
        poll();
        cmd(48'h4200_0210_0000, 48);
        rd(10'h210, 8'hFF, 8'hFF);
        rd(10'h1FE, 8'hA5, 8'h3C);
        rd(10'h3FF, 8'h5A, 8'hFF);
        rd(10'h300, 8'h77, 8'hFF);
        wen();
        cmd(48'h4400_0177_0000, 32);
        poll();
        check("busy seen", {7'h00, busy_seen}, 8'h01);
        rd(10'h1FE, 8'hFF, 8'hFF);
        wen();
        cmd(48'h4400_0300_0000, 33);
        stat(8'h05, st);
        check("latch after abort", st, {protect_bits, 2'h0});
        rd(10'h3FF, 8'h5A, 8'hFF);
        @(posedge sys_clk) page_lock_bits <= 3'h4;
        wen();
        cmd(48'h4400_0300_0000, 32);
        stat(8'h35, st);
        check("status two", st, 8'h20);
        rd(10'h3FF, 8'h5A, 8'hFF);
        @(posedge sys_clk) page_lock_bits <= 3'h0;
        cmd(48'h4400_0300_0000, 32);
        rd(10'h3FF, 8'h5A, 8'hFF);
        host_u.open_frame();
        send(48'h4800_01FE_0000, 40);
        host_u.shift(8'hFF, 3, rx);
        host_u.close_frame();
        check("output enable", {7'h00, so_oe}, 8'h00);
        final_report();
    end
endmodule // test_security_page_flash
